// [src/nbh_host.sv]
// What this block does
// R1 - Command byte: select low, CLE high, strobe
// R2 - Address byte: select low, ALE high, strobe
// R3 - Exactly four address cycles per phase
// R4 - Write data with both latches low
// R5 - Device drives read data, output strobe
// R6 - Each output strobe fall advances column
// R7 - Device stays selected while busy
// R8 - Keep select low through row load busy
// R9 - Program lock low rejects program, erase
// R10 - Program lock acts at level, unsampled
// R11 - Idle flag low while operation runs
// R12 - Open-drain idle flag, low means busy
// R13 - Select high puts device in standby
// R14 - Wait 1us recovery before first command
// R15 - Hold input strobe high during recovery
// R16 - Hold program lock low during recovery
// R17 - Upper lines carry data only
// R18 - Byte-wide address cycle mapping
// R19 - A8 comes from pointer command only
// R20 - Device ignores extra address cycles
// R21 - Word-wide: A8 don't care, same map
// R22 - Device ignores undefined commands
// R23 - Second-half pointer lasts one operation
// R24 - Strobe timing from own clock counts
// R25 - Synchronise idle flag before use
`timescale 1ns/10ps
`default_nettype none
module nbh_host
   import nbh_pkg::*;
#(
   parameter bit WIDE_PORT = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic opValid,
   output logic opReady,
   input wire logic [2:0] opKind,
   input wire logic [BYTE_W-1:0] opCmd,
   input wire logic [ADDR_W-1:0] opAddr,
   input wire logic [DATA_W-1:0] opWord,
   input wire logic writeAllow,
   output logic rdValid,
   input wire logic rdReady,
   output logic [DATA_W-1:0] rdWord,
   output logic lineIdle,
   output logic partSelN,
   output logic cmdLatch,
   output logic addrLatch,
   output logic inStrobeN,
   output logic outStrobeN,
   output logic progLockN,
   output logic [BYTE_W-1:0] portLowByteOut,
   input wire logic [BYTE_W-1:0] portLowByteIn,
   output logic portLowByteOeN,
   output logic [BYTE_W-1:0] portHighByteOut,
   input wire logic [BYTE_W-1:0] portHighByteIn,
   output logic portHighByteOeN,
   input wire logic idleFlag
);
   nbh_state_type state_r;
   nbh_state_type stateNxt;
   nbh_op_type kind_r;
   logic [TIMER_W-1:0] timer_r;
   logic [TIMER_W-1:0] timerNxt;
   logic [1:0] addrCnt_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] word_r;
   logic [BYTE_W-1:0] cmd_r;
   logic idleS1_r;
   logic idleS2_r;
   logic [DATA_W-1:0] portInS1_r;
   logic [DATA_W-1:0] portInS2_r;
   logic fifoInReady;
   logic accept;
   logic cycleEnd;
   logic pushRead;
   logic inCycle;
   logic [BYTE_W-1:0] lowByte;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         idleS1_r <= 1'b1;
         idleS2_r <= 1'b1;
      end
      else
      begin
         idleS1_r <= idleFlag;  // [R25]
         idleS2_r <= idleS1_r;  // [R25]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         portInS1_r <= '0;
         portInS2_r <= '0;
      end
      else
      begin
         portInS1_r <= {portHighByteIn, portLowByteIn};
         portInS2_r <= portInS1_r;
      end
   end

   // ----------------------------------------------------------------
   // Operation intake
   // ----------------------------------------------------------------
   // A read is only started when the FIFO has room for its word, so
   // a stalled consumer holds back the link instead of losing data
   assign accept = opReady && opValid &&
                   (nbh_op_type'(opKind) != OP_READ || fifoInReady);
   assign cycleEnd = (state_r == ST_HIGH) && (timer_r == '0);
   assign pushRead = (state_r == ST_LOW) && (timer_r == '0) &&
                     (kind_r == OP_READ);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         kind_r <= OP_CMD;
         addr_r <= '0;
         word_r <= '0;
         cmd_r <= '0;
      end
      else if (accept)
      begin
         kind_r <= nbh_op_type'(opKind);
         addr_r <= opAddr;
         word_r <= opWord;
         cmd_r <= opCmd;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         addrCnt_r <= '0;
      else if (accept)
         addrCnt_r <= '0;
      else if (cycleEnd && kind_r == OP_ADDR)
         addrCnt_r <= addrCnt_r + 1'b1;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      stateNxt = state_r;
      timerNxt = (timer_r != '0) ? timer_r - 1'b1 : timer_r;
      case (state_r)
         ST_RECOVER:
            if (timer_r == '0)
               stateNxt = ST_IDLE;  // [R14]
         ST_IDLE:
            if (accept)
            begin
               if (nbh_op_type'(opKind) == OP_WAIT)
               begin
                  stateNxt = ST_WAIT;
                  timerNxt = TIMER_W'(BUSY_SETTLE_CYC - 1);
               end
               else if (nbh_op_type'(opKind) != OP_RELEASE)
               begin
                  stateNxt = ST_SETUP;
                  timerNxt = TIMER_W'(SETUP_CYC - 1);  // [R24]
               end
            end
         ST_SETUP:
            if (timer_r == '0)
            begin
               stateNxt = ST_LOW;
               timerNxt = TIMER_W'(STROBE_LOW_CYC - 1);  // [R24]
            end
         ST_LOW:
            if (timer_r == '0)
            begin
               stateNxt = ST_HIGH;
               timerNxt = TIMER_W'(STROBE_HIGH_CYC - 1);  // [R24]
            end
         ST_HIGH:
            if (timer_r == '0)
            begin
               // Four address bytes, never more, never fewer
               if (kind_r == OP_ADDR &&
                   addrCnt_r != 2'(ADDR_CYCLES - 1))  // [R3]
               begin
                  stateNxt = ST_SETUP;
                  timerNxt = TIMER_W'(SETUP_CYC - 1);
               end
               else
                  stateNxt = ST_IDLE;
            end
         ST_WAIT:
            // Low on the shared line means some device is busy
            if (timer_r == '0 && idleS2_r)  // [R12] [R25]
               stateNxt = ST_IDLE;
         default:
            stateNxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= ST_RECOVER;
         timer_r <= TIMER_W'(RECOVERY_CYC - 1);  // [R14]
      end
      else
      begin
         state_r <= stateNxt;
         timer_r <= timerNxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         opReady <= 1'b0;
      else
         opReady <= (stateNxt == ST_IDLE) && !accept;
   end

   // ----------------------------------------------------------------
   // Low byte for the current cycle: command, address or write data
   // ----------------------------------------------------------------
   always_comb
   begin
      lowByte = cmd_r;
      if (kind_r == OP_ADDR)
      begin
         // A8 is skipped: it travels only as the 00h/01h pointer
         case (addrCnt_r)  // [R18] [R19] [R21]
            2'h0: lowByte = addr_r[ADDR_CYC1_LSB +: BYTE_W];
            2'h1: lowByte = addr_r[ADDR_CYC2_LSB +: BYTE_W];
            2'h2: lowByte = addr_r[ADDR_CYC3_LSB +: BYTE_W];
            default: lowByte = {{(BYTE_W - ADDR_CYC4_W){1'b0}},
                                addr_r[ADDR_CYC4_LSB +: ADDR_CYC4_W]};
         endcase
      end
      else if (kind_r == OP_WRITE)
         lowByte = word_r[BYTE_W-1:0];
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   assign inCycle = (stateNxt == ST_SETUP) || (stateNxt == ST_LOW) ||
                    (stateNxt == ST_HIGH);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         partSelN <= 1'b1;
         cmdLatch <= 1'b0;
         addrLatch <= 1'b0;
         inStrobeN <= 1'b1;  // [R15]
         outStrobeN <= 1'b1;
         portLowByteOut <= '0;
         portLowByteOeN <= 1'b1;
         portHighByteOut <= '0;
         portHighByteOeN <= 1'b1;
      end
      else
      begin
         // Select stays low across busy waits until a release op,
         // so a row-load busy period is never cut short
         if (accept)
            partSelN <= (nbh_op_type'(opKind) == OP_RELEASE);  // [R8] [R13]
         cmdLatch <= inCycle && kind_r == OP_CMD;  // [R1]
         addrLatch <= inCycle && kind_r == OP_ADDR;  // [R2]
         inStrobeN <= !(stateNxt == ST_LOW &&
                        kind_r != OP_READ);  // [R1] [R2] [R4]
         outStrobeN <= !(stateNxt == ST_LOW &&
                         kind_r == OP_READ);  // [R5] [R6]
         portLowByteOut <= lowByte;
         portLowByteOeN <= !(inCycle && kind_r != OP_READ);
         // Upper lines are driven for write data on a wide port only
         portHighByteOut <= word_r[DATA_W-1:BYTE_W];
         portHighByteOeN <= !(inCycle && kind_r == OP_WRITE &&
                              WIDE_PORT);  // [R17]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         progLockN <= 1'b0;  // [R16]
      else if (state_r == ST_RECOVER)
         progLockN <= 1'b0;  // [R16]
      else
         progLockN <= writeAllow;  // [R9] [R10]
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         lineIdle <= 1'b1;
      else
         lineIdle <= idleS2_r;  // [R11] [R12]
   end

   // ----------------------------------------------------------------
   // Read data buffer
   // ----------------------------------------------------------------
   // Sampled at the end of the strobe-low phase; the low time must
   // cover the device access time plus two synchroniser cycles
   nbh_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rd_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .inValid(pushRead),
      .inReady(fifoInReady),
      .inData(WIDE_PORT ? portInS2_r :
              {{(DATA_W - BYTE_W){1'b0}}, portInS2_r[BYTE_W-1:0]}),
      .outValid(rdValid),
      .outReady(rdReady),
      .outData(rdWord)
   );
endmodule // nbh_host
`default_nettype wire

// [src/nbh_pkg.sv]
`default_nettype none
package nbh_pkg;
   // ----------------------------------------------------------------
   // Clock and link timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int RECOVERY_NS = 1000;
   localparam int SETUP_NS = 20;
   localparam int STROBE_LOW_NS = 40;
   localparam int STROBE_HIGH_NS = 20;
   localparam int BUSY_SETTLE_NS = 100;
   // Least times, so the counts round up
   localparam int RECOVERY_CYC = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int TIMER_W = 9;

   // ----------------------------------------------------------------
   // Port and address layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 27;
   localparam int ADDR_CYCLES = 4;
   localparam int ADDR_CYC1_LSB = 0;
   localparam int ADDR_CYC2_LSB = 9;
   localparam int ADDR_CYC3_LSB = 17;
   localparam int ADDR_CYC4_LSB = 25;
   localparam int ADDR_CYC4_W = 2;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------------------------------
   // Operation kinds and controller states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_CMD = 3'h0,
      OP_ADDR = 3'h1,
      OP_WRITE = 3'h2,
      OP_READ = 3'h3,
      OP_WAIT = 3'h4,
      OP_RELEASE = 3'h5
   } nbh_op_type;

   typedef enum logic [2:0] {
      ST_RECOVER = 3'h0,
      ST_IDLE = 3'h1,
      ST_SETUP = 3'h3,
      ST_LOW = 3'h2,
      ST_HIGH = 3'h6,
      ST_WAIT = 3'h7
   } nbh_state_type;
endpackage
`default_nettype wire

// [src/nbh_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module nbh_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wrPtr_r;
   logic [PTR_W-1:0] rdPtr_r;
   logic [PTR_W:0] count_r;
   logic full_r;
   logic empty_r;
   logic push;
   logic pop;
   logic [PTR_W:0] countNxt;

   assign push = inValid && !full_r;
   assign pop = outReady && !empty_r;
   assign inReady = !full_r;
   assign outValid = !empty_r;
   assign outData = mem[rdPtr_r];

   always_comb
   begin
      countNxt = count_r;
      if (push && !pop)
         countNxt = count_r + 1'b1;
      else if (pop && !push)
         countNxt = count_r - 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wrPtr_r] <= inData;
   end

   // Flags kept as flops so the top sees clean levels
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
         full_r <= 1'b0;
         empty_r <= 1'b1;
      end
      else
      begin
         if (push)
            wrPtr_r <= (wrPtr_r == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
         if (pop)
            rdPtr_r <= (rdPtr_r == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
         count_r <= countNxt;
         full_r <= (countNxt == (PTR_W + 1)'(DEPTH));
         empty_r <= (countNxt == '0);
      end
   end
endmodule // nbh_fifo
`default_nettype wire

// [tb/nbh_host_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module nbh_host_sva
   import nbh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic opValid,
   input wire logic opReady,
   input wire logic [2:0] opKind,
   input wire logic writeAllow,
   input wire logic lineIdle,
   input wire logic idleFlag,
   input wire logic partSelN,
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic inStrobeN,
   input wire logic outStrobeN,
   input wire logic progLockN,
   input wire logic [BYTE_W-1:0] portLowByteOut,
   input wire logic portLowByteOeN,
   input wire logic portHighByteOeN
);
   logic [8:0] recCnt_r;

   // ----
   // Cycles since reset, saturating
   // ----
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         recCnt_r <= 9'h000;
      else if (recCnt_r != 9'h1ff)
         recCnt_r <= recCnt_r + 9'h001;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   chk_recover_quiet: assert property (recCnt_r < 9'h0f0 |->
      inStrobeN && outStrobeN && partSelN && !progLockN && !opReady)
      else $error("activity during recovery");
   chk_cmd_select: assert property (cmdLatch |->
      !partSelN && !addrLatch && outStrobeN)
      else $error("command latch without select");
   chk_addr_select: assert property (addrLatch |->
      !partSelN && !cmdLatch && outStrobeN)
      else $error("address latch without select");
   chk_data_held: assert property ($rose(inStrobeN) |->
      !portLowByteOeN && $stable(portLowByteOut))
      else $error("write byte not held at strobe rise");
   chk_read_release: assert property (!outStrobeN |->
      portLowByteOeN && inStrobeN && !partSelN && !cmdLatch && !addrLatch)
      else $error("bus driven during read strobe");
   chk_in_pulse: assert property ($fell(inStrobeN) |->
      ##9 !inStrobeN ##1 inStrobeN)
      else $error("input strobe low time wrong");
   chk_out_pulse: assert property ($fell(outStrobeN) |->
      ##9 !outStrobeN ##1 outStrobeN)
      else $error("output strobe low time wrong");
   chk_upper_quiet: assert property ((cmdLatch || addrLatch) |->
      portHighByteOeN)
      else $error("upper lines driven in command or address");
   chk_lock_follow: assert property (recCnt_r > 9'h104 |->
      progLockN == $past(writeAllow))
      else $error("program lock does not follow allow");
   chk_idle_sync: assert property (recCnt_r > 9'h004 |->
      lineIdle == $past(idleFlag, 3))
      else $error("idle flag sync latency wrong");
   chk_select_drop: assert property ($rose(partSelN) |->
      $past(opValid && opReady) && $past(opKind) == OP_RELEASE)
      else $error("select raised without release");
   chk_ready_drop: assert property (
      opValid && opReady && opKind != OP_READ |=> !opReady)
      else $error("ready stays high after take");

   cover property ($rose(inStrobeN) && cmdLatch);
   cover property ($fell(outStrobeN));
   cover property ($fell(lineIdle));
   cover property ($rose(partSelN));
endmodule // nbh_host_sva
`default_nettype wire

// [tb/nbh_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
module nbh_flash_model (
   input wire logic ref_clk,
   input wire logic partSelN,
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic inStrobeN,
   input wire logic outStrobeN,
   input wire logic progLockN,
   input wire logic [7:0] hostLow,
   input wire logic hostLowOeN,
   input wire logic [7:0] hostHigh,
   input wire logic hostHighOeN,
   output logic [7:0] busLow,
   output logic [7:0] busHigh,
   output logic idleFlag
);
   logic [7:0] lastCmd = 8'h00;
   logic [7:0] dout = 8'h00;
   logic [7:0] col = 8'h00;
   logic [7:0] lastLow = 8'h00;
   logic [7:0] lastHigh = 8'h00;
   logic [7:0] addrB [4];
   logic [7:0] wr [4];
   int addrN = 0;
   int wrN = 0;
   int progN = 0;
   int rdN = 0;
   int busyCnt = 0;
   logic devDrv;

   // ----
   // Pins
   // ----
   assign devDrv = !partSelN && !outStrobeN && inStrobeN &&
      !cmdLatch && !addrLatch;
   // Released lines flip each cycle so a stale sample cannot pass
   assign busLow = !hostLowOeN ? hostLow : (devDrv ? dout : ~lastLow);
   assign busHigh = !hostHighOeN ? hostHigh : ~lastHigh;
   assign idleFlag = (busyCnt == 0);
   // Busy count steps after the edge so the host never samples a race
   always @(posedge ref_clk)
   begin
      lastLow <= busLow;
      lastHigh <= busHigh;
      if (busyCnt > 0)
         busyCnt <= busyCnt - 1;
   end
   always @(negedge outStrobeN)
   begin
      if (!partSelN)
      begin
         dout = col ^ 8'ha5;
         col = col + 8'h01;
         rdN = rdN + 1;
      end
   end

   // ----
   // Captures on input strobe rise
   // ----
   always @(posedge inStrobeN)
   begin
      if (!partSelN && outStrobeN && cmdLatch && !addrLatch)
      begin
         lastCmd = hostLow;
         if (hostLow != 8'h10)
            addrN = 0;
         if (hostLow == 8'h80)
            wrN = 0;
         if (hostLow == 8'h10 && progLockN)
         begin
            progN = progN + 1;
            busyCnt = 40;
         end
      end
      if (!partSelN && outStrobeN && addrLatch && !cmdLatch)
      begin
         if (addrN < 4)
            addrB[addrN] = hostLow;
         addrN = addrN + 1;
         // Only the first-half pointer starts a read here
         if (addrN == 4 && lastCmd == 8'h00)
         begin
            col = addrB[0];
            busyCnt = 30;
         end
      end
      if (!partSelN && outStrobeN && !addrLatch && !cmdLatch)
      begin
         if (wrN < 4)
            wr[wrN] = hostLow;
         wrN = wrN + 1;
      end
   end
endmodule // nbh_flash_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   import nbh_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic opValid = 1'b0;
   logic [2:0] opKind = 3'h0;
   logic [7:0] opCmd = 8'h00;
   logic [ADDR_W-1:0] opAddr = 27'h0000000;
   logic [15:0] opWord = 16'h0000;
   logic writeAllow = 1'b0;
   logic rdReady = 1'b0;
   logic opReady, rdValid, lineIdle, partSelN, cmdLatch, addrLatch;
   logic inStrobeN, outStrobeN, progLockN, lowOeN, highOeN, idleFlag;
   logic [15:0] rdWord;
   logic [7:0] lowOut, lowIn, highOut, highIn;
   int err_count = 0;
   int n_tests = 0;

   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   nbh_host #(.WIDE_PORT(1'b0)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .opValid(opValid), .opReady(opReady), .opKind(opKind),
      .opCmd(opCmd), .opAddr(opAddr), .opWord(opWord),
      .writeAllow(writeAllow), .rdValid(rdValid), .rdReady(rdReady),
      .rdWord(rdWord), .lineIdle(lineIdle), .partSelN(partSelN),
      .cmdLatch(cmdLatch), .addrLatch(addrLatch), .inStrobeN(inStrobeN),
      .outStrobeN(outStrobeN), .progLockN(progLockN),
      .portLowByteOut(lowOut), .portLowByteIn(lowIn),
      .portLowByteOeN(lowOeN), .portHighByteOut(highOut),
      .portHighByteIn(highIn), .portHighByteOeN(highOeN),
      .idleFlag(idleFlag));

   nbh_flash_model flash (.ref_clk(ref_clk), .partSelN(partSelN),
      .cmdLatch(cmdLatch), .addrLatch(addrLatch), .inStrobeN(inStrobeN),
      .outStrobeN(outStrobeN), .progLockN(progLockN), .hostLow(lowOut),
      .hostLowOeN(lowOeN), .hostHigh(highOut), .hostHighOeN(highOeN),
      .busLow(lowIn), .busHigh(highIn), .idleFlag(idleFlag));

   // ----
   // Shared tasks
   // ----
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      if (err_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (opReady !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
         check("opReady", 16'h1, 16'h0);
         finish_test();
      end
   endtask
   task automatic do_op(input logic [2:0] k, input logic [7:0] c,
      input logic [26:0] a, input logic [15:0] w);
      @(posedge ref_clk);
      #1;
      opKind = k;
      opCmd = c;
      opAddr = a;
      opWord = w;
      opValid = 1'b1;
      wait_ready();
      #1;
      opValid = 1'b0;
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_recovery();
      int n;
      n = 0;
      while (opReady !== 1'b1 && n < 1000)
      begin
         @(posedge ref_clk);
         n++;
      end
      check("recovery", 16'h1, 16'(n >= RECOVERY_CYC));
      check("lock", 16'h0, {15'h0, progLockN});
   endtask
   task automatic t_program(input logic allow, input int expP);
      logic [26:0] a;
      a = 27'h5a3c1e7 ^ {26'h0, allow};
      @(posedge ref_clk);
      #1;
      writeAllow = allow;
      do_op(OP_CMD, 8'h80, a, 16'h0000);
      do_op(OP_ADDR, 8'h00, a, 16'h0000);
      for (int i = 0; i < 3; i++)
         do_op(OP_WRITE, 8'h00, a, 16'hc3a0 + 16'(i));
      do_op(OP_CMD, 8'h10, a, 16'h0000);
      do_op(OP_WAIT, 8'h00, a, 16'h0000);
      wait_ready();
      check("cmd", 16'h0010, {8'h0, flash.lastCmd});
      check("addr0", {8'h0, a[7:0]}, {8'h0, flash.addrB[0]});
      check("addr1", {8'h0, a[16:9]}, {8'h0, flash.addrB[1]});
      check("addr2", {8'h0, a[24:17]}, {8'h0, flash.addrB[2]});
      check("addr3", {14'h0, a[26:25]}, {8'h0, flash.addrB[3]});
      check("addr count", 16'h4, 16'(flash.addrN));
      check("write count", 16'h3, 16'(flash.wrN));
      for (int i = 0; i < 3; i++)
         check("write", 16'ha0 + 16'(i), {8'h0, flash.wr[i]});
      check("programs", 16'(expP), 16'(flash.progN));
      check("idle", 16'h1, {15'h0, lineIdle});
      check("select", 16'h0, {15'h0, partSelN});
   endtask
   task automatic t_read();
      logic [26:0] a;
      int r0, k, n;
      a = 27'h12345f8;
      do_op(OP_CMD, 8'h00, a, 16'h0000);
      do_op(OP_ADDR, 8'h00, a, 16'h0000);
      do_op(OP_WAIT, 8'h00, a, 16'h0000);
      r0 = flash.rdN;
      for (int i = 0; i < 8; i++)
         do_op(OP_READ, 8'h00, a, 16'h0000);
      wait_ready();
      #1;
      opValid = 1'b1;
      repeat (60) @(posedge ref_clk);
      check("refused read", 16'(r0 + 8), 16'(flash.rdN));
      check("full valid", 16'h1, {15'h0, rdValid});
      #1;
      rdReady = 1'b1;
      k = 0;
      n = 0;
      while (k < 9 && n < 3000)
      begin
         @(posedge ref_clk);
         n++;
         if (flash.rdN == r0 + 9)
            opValid <= 1'b0;
         if (rdValid === 1'b1)
         begin
            check("read", {8'h0, (a[7:0] + 8'(k)) ^ 8'ha5}, rdWord);
            k++;
         end
      end
      check("drained", 16'h9, 16'(k));
      #1;
      rdReady = 1'b0;
   endtask
   task automatic t_release();
      do_op(OP_RELEASE, 8'h00, 27'h0, 16'h0000);
      @(posedge ref_clk);
      #1;
      check("standby", 16'h1, {15'h0, partSelN});
   endtask

   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1;
      rst_b = 1'b1;
      t_recovery();
      t_program(1'b0, 0);
      t_program(1'b1, 1);
      t_read();
      t_release();
      finish_test();
   end
endmodule // tb

bind nbh_host nbh_host_sva chk (.*);
`default_nettype wire
